// >>> core/motor_prot_regs.svh
`ifndef MOTOR_PROT_REGS_SVH
`define MOTOR_PROT_REGS_SVH

// Clock rate and thermal tick
`define MP_CLK_KHZ      25000
`define MP_TICK_MS      100
// Recovery periods in seconds
`define MP_MOTOR_REC_S  300
`define MP_THY_REC_S    30
`define MP_BYP_REC_S    60
// Trip classes in seconds to trip from cold at 7.2 x rated current
`define MP_CLASS10_S    10
`define MP_CLASS15_S    15
`define MP_CLASS20_S    20
// Heat margin at 7.2 x rated current, scaled by 100: 7.2^2 - 1
`define MP_HEAT_X100    5084
// Fixed thyristor trip value
`define MP_THY_TRIP     10'h0c8
// Reset values
`define MP_ACCUM_RST    40'h0
`define MP_CNT_RST      12'h0

`endif

// >>> core/motor_prot_pkg.sv
package motor_prot_pkg;

   typedef enum logic [3:0] {
      ST_IDLE    = 4'b0001,
      ST_RUN     = 4'b0010,
      ST_RECOVER = 4'b0100,
      ST_TRIPPED = 4'b1000
   } prot_state_e;

   typedef enum logic [2:0] {
      CAUSE_NONE   = 3'h0,
      CAUSE_MOTOR  = 3'h1,
      CAUSE_THY    = 3'h2,
      CAUSE_BYPASS = 3'h3,
      CAUSE_SENSOR = 3'h4
   } trip_cause_e;

   typedef struct packed {
      prot_state_e state;
      trip_cause_e cause;
      logic [31:0] tick_cnt;
      logic        tick;
      logic [11:0] rec_cnt;
      logic [39:0] accum;
      logic [11:0] ie;
      logic        motor_on;
      logic        fault;
      logic        setting_fault;
   } prot_regs_s;

endpackage : motor_prot_pkg

// >>> core/motor_protection_trip_recovery.sv
`timescale 1ns/1ps
`include "motor_prot_regs.svh"
// Behaviour
// - Motor model trip: five minute recovery, no restart before it ends.
// - Self-protection trip: 30 s for thyristors, 60 s for bypass.
// - Winding sensor trip: blocked until sensor reports cooled down.
// - Winding heating computed from current relative to rated motor current.
// - Overload trip when model reaches selected trip class characteristic.
// - Class sets cold trip time at 7.2 times rated current.
// - Rated current setting accepted only below starter rated current.
// - Supply loss during motor trip keeps trip and remaining time.
// - Supply loss during self-protection trip keeps trip and remaining time.
// - Supply loss without a trip keeps no thermal state.
// - Thyristor evaluation over fixed threshold disconnects the motor.
// - Sensor input selects thermistor or bimetal switch, separate terminals.
// - Sensor open wire or short circuit is a fault.
module motor_protection_trip_recovery #(
   parameter int                  TICK_CYCLES   = `MP_TICK_MS * `MP_CLK_KHZ,
   parameter logic [11:0]         STARTER_RATED = 12'h400
) (
   input  wire logic                        clk,
   input  wire logic                        rst,
   input  wire logic                        supply_ok,
   input  wire logic                        start_req,
   input  wire logic                        ack_req,
   input  wire logic [11:0]                 phase_current,
   input  wire logic [11:0]                 rated_current_cfg,
   input  wire logic [1:0]                  trip_class_sel,
   input  wire logic [9:0]                  heatsink_temp,
   input  wire logic                        bypass_overload,
   input  wire logic                        sensor_en,
   input  wire logic                        sensor_kind,
   input  wire logic                        ptc_hot,
   input  wire logic                        ptc_open_wire,
   input  wire logic                        ptc_short,
   input  wire logic                        bimetal_open,
   input  wire logic                        bimetal_wire_fault,
   output logic                             motor_on,
   output logic                             fault_out,
   output motor_prot_pkg::trip_cause_e      trip_cause,
   output logic                             recovery_busy,
   output logic                             setting_fault
);
   import motor_prot_pkg::*;

   localparam int          TICKS_PER_S  = 1000 / `MP_TICK_MS;
   localparam logic [11:0] MOTOR_TICKS  = 12'(`MP_MOTOR_REC_S * TICKS_PER_S);
   localparam logic [11:0] THY_TICKS    = 12'(`MP_THY_REC_S * TICKS_PER_S);
   localparam logic [11:0] BYP_TICKS    = 12'(`MP_BYP_REC_S * TICKS_PER_S);
   localparam logic [31:0] TICK_LAST    = 32'(TICK_CYCLES - 1);

   prot_regs_s  s_r;
   prot_regs_s  s_nxt;

   logic [23:0] cur_sq;
   logic [23:0] ie_sq;
   logic [15:0] class_k;
   logic [39:0] trip_level;
   logic [40:0] heat_sum;
   logic [10:0] thy_eval;
   logic        class_ok;
   logic        motor_trip;
   logic        thy_trip;
   logic        sensor_hot;
   logic        sensor_wire;
   logic        sensor_trip;
   logic        any_trip;

   function automatic logic [15:0] class_scale(input logic [1:0] sel);
      int secs;
      secs = 0;
      case (sel)
         2'h0:    secs = `MP_CLASS10_S;
         2'h1:    secs = `MP_CLASS15_S;
         2'h2:    secs = `MP_CLASS20_S;
         default: secs = 0;
      endcase
      return 16'((`MP_HEAT_X100 * secs * TICKS_PER_S) / 100);
   endfunction : class_scale

   always_comb begin
      class_k    = class_scale(trip_class_sel);
      class_ok   = (trip_class_sel != 2'h3);
      cur_sq     = 24'(phase_current * phase_current);
      ie_sq      = 24'(s_r.ie * s_r.ie);
      trip_level = 40'(ie_sq * class_k);
      heat_sum   = {1'b0, s_r.accum} + {17'h0, cur_sq};
      // Invalid class gives a zero level, which must not trip
      motor_trip = (s_r.accum >= trip_level) && (s_r.ie != 12'h0) && class_ok;
      thy_eval   = {1'b0, heatsink_temp} + {3'h0, phase_current[11:4]};
      thy_trip   = (thy_eval > {1'b0, `MP_THY_TRIP});
      sensor_hot  = sensor_kind ? bimetal_open : ptc_hot;
      sensor_wire = sensor_kind ? bimetal_wire_fault : (ptc_open_wire | ptc_short);
      sensor_trip = sensor_en && (sensor_hot || sensor_wire);
      any_trip    = motor_trip || thy_trip || bypass_overload || sensor_trip;
   end

   always_comb begin
      s_nxt      = s_r;
      s_nxt.tick = 1'b0;
      if (s_r.tick_cnt >= TICK_LAST) begin
         s_nxt.tick_cnt = 32'h0;
         s_nxt.tick     = 1'b1;
      end else begin
         s_nxt.tick_cnt = s_r.tick_cnt + 32'h1;
      end
      // Rating taken only below starter rating, while stopped
      if (s_r.state == ST_IDLE) begin
         s_nxt.setting_fault = (rated_current_cfg >= STARTER_RATED) || !class_ok;
         if ((rated_current_cfg < STARTER_RATED) && class_ok) begin
            s_nxt.ie = rated_current_cfg;
         end
      end
      // Thermal model keeps cooling during recovery
      if (s_r.tick) begin
         if (heat_sum > {17'h0, ie_sq}) begin
            s_nxt.accum = 40'(heat_sum - {17'h0, ie_sq});
         end else begin
            s_nxt.accum = `MP_ACCUM_RST;
         end
      end
      if (!supply_ok) begin
         s_nxt.motor_on = 1'b0;
         s_nxt.tick_cnt = s_r.tick_cnt;
         // Pending tick held so an outage loses no time
         s_nxt.tick     = s_r.tick;
         if ((s_r.state == ST_RECOVER) || (s_r.state == ST_TRIPPED)) begin
            // Motor trip and remaining time frozen
            s_nxt.accum = s_r.accum;
         end else begin
            s_nxt.accum = `MP_ACCUM_RST;
            s_nxt.state = ST_IDLE;
         end
      end else begin
         case (s_r.state)
            ST_IDLE, ST_RUN: begin
               if (any_trip) begin
                  s_nxt.state    = ST_RECOVER;
                  s_nxt.motor_on = 1'b0;
                  s_nxt.fault    = 1'b1;
                  // Longest recovery wins when several trip together
                  if (motor_trip) begin
                     s_nxt.cause   = CAUSE_MOTOR;
                     s_nxt.rec_cnt = MOTOR_TICKS;
                  end else if (bypass_overload) begin
                     s_nxt.cause   = CAUSE_BYPASS;
                     s_nxt.rec_cnt = BYP_TICKS;
                  end else if (thy_trip) begin
                     s_nxt.cause   = CAUSE_THY;
                     s_nxt.rec_cnt = THY_TICKS;
                  end else begin
                     // Sensor recovery has no fixed time
                     s_nxt.cause   = CAUSE_SENSOR;
                     s_nxt.rec_cnt = `MP_CNT_RST;
                  end
               end else if (s_r.state == ST_IDLE) begin
                  if (start_req && !s_r.setting_fault) begin
                     s_nxt.state    = ST_RUN;
                     s_nxt.motor_on = 1'b1;
                  end
               end else if (!start_req) begin
                  s_nxt.state    = ST_IDLE;
                  s_nxt.motor_on = 1'b0;
               end
            end
            ST_RECOVER: begin
               s_nxt.motor_on = 1'b0;
               s_nxt.fault    = 1'b1;
               if (s_r.rec_cnt != `MP_CNT_RST) begin
                  if (s_r.tick) begin
                     s_nxt.rec_cnt = s_r.rec_cnt - 12'h1;
                  end
               end else if ((s_r.cause != CAUSE_SENSOR) || !sensor_trip) begin
                  s_nxt.state = ST_TRIPPED;
               end
            end
            ST_TRIPPED: begin
               // Late acknowledge; a new trip source keeps it latched
               if (ack_req && !any_trip) begin
                  s_nxt.state = ST_IDLE;
                  s_nxt.fault = 1'b0;
                  s_nxt.cause = CAUSE_NONE;
               end
            end
            default: begin
               s_nxt.state    = ST_IDLE;
               s_nxt.motor_on = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_r               <= '0;
         s_r.state         <= ST_IDLE;
         s_r.cause         <= CAUSE_NONE;
         s_r.accum         <= `MP_ACCUM_RST;
         s_r.rec_cnt       <= `MP_CNT_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign motor_on      = s_r.motor_on;
   assign fault_out     = s_r.fault;
   assign trip_cause    = s_r.cause;
   // One-hot bit, so the output comes straight from a flop
   assign recovery_busy = s_r.state[2];
   assign setting_fault = s_r.setting_fault;

   a_motor_rec_len: assert property (@(posedge clk) disable iff (rst)
      (s_r.state != ST_RECOVER) ##1 (s_r.state == ST_RECOVER && s_r.cause == CAUSE_MOTOR)
      |-> s_r.rec_cnt == MOTOR_TICKS)
      else $error("motor recovery length wrong");

   a_byp_rec_len: assert property (@(posedge clk) disable iff (rst)
      $rose(s_r.state == ST_RECOVER) && s_r.cause == CAUSE_BYPASS |-> s_r.rec_cnt == BYP_TICKS)
      else $error("bypass recovery length wrong");

   a_thy_rec_len: assert property (@(posedge clk) disable iff (rst)
      $rose(s_r.state == ST_RECOVER) && s_r.cause == CAUSE_THY |-> s_r.rec_cnt == THY_TICKS)
      else $error("thyristor recovery length wrong");

   a_sensor_hold: assert property (@(posedge clk) disable iff (rst)
      s_r.state == ST_RECOVER && s_r.cause == CAUSE_SENSOR && sensor_trip |=> s_r.state == ST_RECOVER)
      else $error("sensor recovery left while hot");

   a_overload_trip: assert property (@(posedge clk) disable iff (rst)
      supply_ok && s_r.state == ST_RUN && motor_trip |=> s_r.state == ST_RECOVER && s_r.cause == CAUSE_MOTOR)
      else $error("overload trip missed");

   a_setting_block: assert property (@(posedge clk) disable iff (rst)
      s_r.state == ST_IDLE && s_r.setting_fault |=> !s_r.motor_on)
      else $error("motor started with bad setting");

   a_supply_keep: assert property (@(posedge clk) disable iff (rst)
      s_r.state == ST_RECOVER && !supply_ok |=> s_r.state == ST_RECOVER && s_r.rec_cnt == $past(s_r.rec_cnt))
      else $error("trip state lost on supply loss");

   a_no_trip_clear: assert property (@(posedge clk) disable iff (rst)
      !supply_ok && (s_r.state == ST_RUN || s_r.state == ST_IDLE) |=> s_r.accum == 40'h0)
      else $error("thermal state kept without trip");

   a_thy_trip: assert property (@(posedge clk) disable iff (rst)
      supply_ok && s_r.state == ST_RUN && thy_trip |=> !s_r.motor_on ##0 s_r.fault)
      else $error("thyristor overload did not disconnect");

   a_wire_fault: assert property (@(posedge clk) disable iff (rst)
      supply_ok && sensor_en && sensor_wire && s_r.state == ST_IDLE |=> s_r.state == ST_RECOVER)
      else $error("sensor wire fault not tripped");

   a_rec_ignore: assert property (@(posedge clk) disable iff (rst)
      s_r.state == ST_RECOVER |-> !s_r.motor_on && s_r.fault ##1 s_r.state != ST_IDLE)
      else $error("recovery not held");

   a_tick_period: assert property (@(posedge clk) disable iff (rst)
      s_r.tick && $past(supply_ok) |-> $past(s_r.tick_cnt) == TICK_LAST)
      else $error("tick out of place");

   a_recover_hold: assert property (@(posedge clk) disable iff (rst)
      s_r.state == ST_RECOVER && s_r.rec_cnt != 12'h0 |=> s_r.state == ST_RECOVER)
      else $error("recovery left before count ran out");

   a_thy_cause: assert property (@(posedge clk) disable iff (rst)
      supply_ok && s_r.state == ST_RUN && thy_trip && !motor_trip && !bypass_overload |=> s_r.cause == CAUSE_THY)
      else $error("thyristor trip cause wrong");

   a_rated_take: assert property (@(posedge clk) disable iff (rst)
      s_r.state == ST_IDLE && rated_current_cfg < STARTER_RATED && trip_class_sel != 2'h3
      |=> s_r.ie == $past(rated_current_cfg))
      else $error("valid rating not taken");

   a_model_keep: assert property (@(posedge clk) disable iff (rst)
      s_r.state == ST_RECOVER && !supply_ok |=> s_r.accum == $past(s_r.accum))
      else $error("thermal model lost on supply loss");

   a_self_keep: assert property (@(posedge clk) disable iff (rst)
      s_r.state == ST_RECOVER && !supply_ok |=> s_r.cause == $past(s_r.cause) && s_r.fault && !s_r.motor_on)
      else $error("trip cause lost on supply loss");

   a_pair_select: assert property (@(posedge clk) disable iff (rst)
      supply_ok && s_r.state == ST_RUN && sensor_en && sensor_kind && bimetal_open |=> s_r.state == ST_RECOVER)
      else $error("switch pair not evaluated");

endmodule : motor_protection_trip_recovery

// >>> verification/motor_side_model.sv
`timescale 1ns/1ps
module motor_side_model (
   input  wire logic        motor_on,
   input  wire logic        fault_out,
   input  wire logic [11:0] load,
   input  wire logic        kind,
   input  wire logic        hot,
   input  wire logic [1:0]  werr,
   output logic [11:0]      phase_current,
   output logic             ptc_hot,
   output logic             ptc_open_wire,
   output logic             ptc_short,
   output logic             bimetal_open,
   output logic             bimetal_wire_fault
);
   logic feeder_closed;
   assign feeder_closed = !fault_out;
   // No current once the feeder is open, so the model cools
   assign phase_current = (motor_on && feeder_closed) ? load : 12'h000;
   assign ptc_hot            = !kind && hot;
   assign ptc_open_wire      = !kind && werr == 2'h1;
   assign ptc_short          = !kind && werr == 2'h2;
   assign bimetal_open       = kind && hot;
   assign bimetal_wire_fault = kind && werr != 2'h0;
endmodule : motor_side_model

// >>> verification/motor_protection_trip_recovery_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
   $display("BAD %s exp %0h got %0h", nm, e, g); end end
module motor_protection_trip_recovery_tb;
   import motor_prot_pkg::*;
   logic        clk = 0, rst = 1, supply_ok = 1, start_req = 0, ack_req = 0, byp_ovl = 0;
   logic        sensor_en = 0, sensor_kind = 0, hot = 0, pair = 0;
   logic [1:0]  werr = 0, cls = 0;
   logic [11:0] load = 0, rated = 12'h064, phase_current;
   logic [9:0]  hs = 10'h010;
   logic        ptc_hot, ptc_open_wire, ptc_short, bimetal_open, bimetal_wire_fault;
   logic        motor_on, fault_out, recovery_busy, setting_fault;
   trip_cause_e trip_cause;
   int          mismatches = 0, samples_checked = 0;

   always #20 clk = ~clk;

   motor_protection_trip_recovery #(.TICK_CYCLES(4)) i_motor_protection_trip_recovery (
      .clk(clk), .rst(rst), .supply_ok(supply_ok), .start_req(start_req), .ack_req(ack_req),
      .phase_current(phase_current), .rated_current_cfg(rated), .trip_class_sel(cls),
      .heatsink_temp(hs), .bypass_overload(byp_ovl), .sensor_en(sensor_en), .sensor_kind(sensor_kind),
      .ptc_hot(ptc_hot), .ptc_open_wire(ptc_open_wire), .ptc_short(ptc_short),
      .bimetal_open(bimetal_open), .bimetal_wire_fault(bimetal_wire_fault), .motor_on(motor_on),
      .fault_out(fault_out), .trip_cause(trip_cause), .recovery_busy(recovery_busy),
      .setting_fault(setting_fault));

   motor_side_model i_motor_side_model (
      .motor_on(motor_on), .fault_out(fault_out), .load(load), .kind(pair), .hot(hot),
      .werr(werr), .phase_current(phase_current), .ptc_hot(ptc_hot), .ptc_open_wire(ptc_open_wire),
      .ptc_short(ptc_short), .bimetal_open(bimetal_open), .bimetal_wire_fault(bimetal_wire_fault));

   task automatic close_out;
      $display("checked %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : close_out

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask : cyc

   task automatic wait_sig(input bit busy, input logic exp, input int lim, output int n);
      n = 0;
      while (((busy ? recovery_busy : fault_out) !== exp) && n < lim) begin
         cyc(1);
         n++;
      end
      if (n >= lim) begin
         mismatches++;
         $display("BAD wait busy=%0d exp %0h got timeout", busy, exp);
         close_out();
      end
   endtask : wait_sig

   task automatic ack;
      ack_req = 1;
      cyc(1);
      ack_req = 0;
      cyc(3);
   endtask : ack

   // Trip already seen; outage of d cycles must extend recovery by d
   task automatic rec_check(input int ticks, input int d, input trip_cause_e c);
      int n;
      cyc(100);
      ack_req = 1;
      supply_ok = 0;
      cyc(d);
      `CHK("held_cause", c, trip_cause)
      `CHK("held_fault", 1'b1, fault_out)
      supply_ok = 1;
      cyc(20);
      `CHK("ack_ignored", 1'b1, fault_out)
      `CHK("start_ignored", 1'b0, motor_on)
      ack_req = 0;
      wait_sig(1, 1'b0, ticks * 4 - 104, n);
      `CHK("rec_len", 1'b1, n >= ticks * 4 - 128)
      `CHK("latched", 1'b1, fault_out)
      load = 12'h064;
      ack();
      `CHK("ack_cause", CAUSE_NONE, trip_cause)
      `CHK("restart", 1'b1, motor_on)
   endtask : rec_check

   task automatic t_setting;
      rated = 12'h400;
      cyc(3);
      `CHK("rate_max", 1'b1, setting_fault)
      start_req = 1;
      cyc(3);
      `CHK("start_refused", 1'b0, motor_on)
      start_req = 0;
      rated = 12'h3ff;
      cyc(3);
      `CHK("rate_ok", 1'b0, setting_fault)
      cls = 2'h3;
      cyc(3);
      `CHK("class_bad", 1'b1, setting_fault)
      `CHK("class_no_trip", 1'b0, fault_out)
      cls = 2'h0;
      rated = 12'h064;
      cyc(3);
      $display("done setting");
   endtask : t_setting

   task automatic t_self(input bit byp);
      int n;
      start_req = 1;
      load = 12'h064;
      hs = 10'h0c2;
      cyc(8);
      `CHK("at_limit", 1'b1, motor_on)
      if (byp)
         byp_ovl = 1;
      else
         hs = 10'h0c3;
      wait_sig(0, 1'b1, 4, n);
      `CHK("disconnect", 1'b0, motor_on)
      byp_ovl = 0;
      hs = 10'h010;
      if (byp)
         rec_check(600, 40, CAUSE_BYPASS);
      else
         rec_check(300, 40, CAUSE_THY);
      $display("done self %0d", byp);
   endtask : t_self

   task automatic t_sens(input bit k, input int m);
      int n;
      sensor_en = 1;
      sensor_kind = k;
      pair = !k;
      hot = (m == 0);
      werr = m[1:0];
      cyc(3);
      `CHK("wrong_pair", 1'b0, fault_out)
      pair = k;
      wait_sig(0, 1'b1, 4, n);
      `CHK("sens_cause", CAUSE_SENSOR, trip_cause)
      cyc(200);
      `CHK("sens_hold", 1'b1, recovery_busy)
      hot = 0;
      werr = 0;
      wait_sig(1, 1'b0, 8, n);
      ack();
      `CHK("sens_clear", 1'b0, fault_out)
      sensor_en = 0;
      $display("done sensor %0d %0d", k, m);
   endtask : t_sens

   // Cold trip at 7.2 x rated within the class time
   task automatic t_class(input logic [1:0] c, input bit pre);
      int n;
      int t;
      t = (10 + 5 * c) * 40;
      start_req = 0;
      cls = c;
      load = 12'h2d0;
      rst = 1;
      cyc(3);
      rst = 0;
      cyc(2);
      start_req = 1;
      if (pre) begin
         cyc(240);
         supply_ok = 0;
         cyc(10);
         supply_ok = 1;
      end
      wait_sig(0, 1'b1, t + 16, n);
      `CHK("class_time", 1'b1, n >= t * 9 / 10)
      `CHK("ovl_cause", CAUSE_MOTOR, trip_cause)
      $display("done class %0d %0d", c, pre);
   endtask : t_class

   initial begin
      cyc(3);
      rst = 0;
      cyc(1);
      t_setting();
      t_self(0);
      t_self(1);
      for (int k = 0; k < 2; k++)
         for (int m = 0; m < 3; m++)
            t_sens(k[0], m);
      t_class(2'h2, 0);
      t_class(2'h1, 0);
      t_class(2'h0, 1);
      t_class(2'h0, 0);
      // Restart only after five minutes, supply dropped meanwhile
      rec_check(3000, 400, CAUSE_MOTOR);
      $display("done motor recovery");
      close_out();
   end
endmodule : motor_protection_trip_recovery_tb
